// File: core/async_timer_pkg.sv
// Purpose: Shared constants and types for the asynchronous timer register crossing.
// Assumes: Registers sit on a classic Wishbone slave with 32-bit data, one word each.
// Notes:   Offsets are byte addresses; 8-bit registers live in the low byte.
`default_nettype none

package async_timer_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_COUNT   = 8'h00;  // Live counter value.
  localparam logic [7:0] OFS_COMPARE = 8'h04;  // Compare value, holding copy on read.
  localparam logic [7:0] OFS_CONTROL = 8'h08;  // Counter control, holding copy on read.
  localparam logic [7:0] OFS_STATUS  = 8'h0c;  // Clock select and pending-update flags.
  localparam logic [7:0] OFS_FLAGS   = 8'h10;  // Overflow and compare flags, write one to clear.

  // Path indices; each also names its pending bit in the status register.
  localparam int unsigned PATH_CONTROL = 0;
  localparam int unsigned PATH_COMPARE = 1;
  localparam int unsigned PATH_COUNT   = 2;
  localparam int unsigned NUM_PATHS    = 3;

  // Status, flags and control field positions.
  localparam int unsigned BIT_ASYNC_SEL = 3;   // Status bit: clock from the oscillator pin.
  localparam int unsigned BIT_FLAG_OVF  = 0;   // Flags bit: counter wrapped.
  localparam int unsigned BIT_FLAG_CMP  = 1;   // Flags bit: compare match.
  localparam int unsigned BIT_CTL_TOGGLE = 4;  // Control bit: toggle compare pin on match.
  localparam int unsigned CTL_CS_MSB    = 2;   // Control clock-select field, upper bit.

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Timing figures.
  localparam int unsigned XFER_EDGES     = 2;  // Oscillator edges before a transfer lands.
  localparam int unsigned FLAG_CPU_DELAY = 3;  // CPU cycles of flag synchronisation.
  localparam int unsigned WAKE_STALL     = 4;  // CPU cycles the processor is held on wake.

  // Wishbone request bundle from the master.
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } wb_req_t;

  // Wake sequencer, Gray coded along its loop.
  typedef enum logic [1:0] {
    WK_IDLE  = 2'b00,
    WK_WAIT  = 2'b01,
    WK_STALL = 2'b11,
    WK_REARM = 2'b10
  } wake_state_t;

endpackage

`default_nettype wire

// File: core/async_timer_register_sync.sv
// Purpose: Holding registers, pending flags and flag return path of an 8-bit timer
//          that can count from a slow oscillator pin while the CPU reaches it over Wishbone.
// Assumes: One clock clk_i; the oscillator pin is an ordinary input, synchronised here.
// Notes:   Prescaler and PWM are not modelled; any nonzero clock-select code counts each tick.
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`default_nettype none

// Functional notes
// [RL1] Count write sets counter pending, transfer clears
// [RL2] Compare write sets compare pending, transfer clears
// [RL3] Control write sets control pending, transfer clears
// [RL4] Software avoids writing while pending
// [RL5] Count reads live; others read holding
// [RL6] Holding value lands after two oscillator edges
// [RL7] Independent holding register per destination
// [RL8] Software follows clock-switch sequence
// [RL9] No compare match while count/compare pending
// [RL10] Software waits pending clear before sleeping
// [RL11] Wake logic needs one oscillator cycle rearm
// [RL12] Software ensures oscillator cycle before resleep
// [RL13] Oscillator runs except in power-down
// [RL14] Software waits one second after power-up
// [RL15] Wake starts on next timer tick
// [RL16] Processor stalls four cycles on wake
// [RL17] Flags arrive three CPU cycles plus tick
// [RL18] Compare pin driven by timer tick directly
// [RL19] Clock select picks oscillator or system clock
// [RL20] Crossings use two-stage synchronisers
module async_timer_register_sync (
  input  wire logic                     clk_i,         // System clock, 125 MHz.
  input  wire logic                     rst_i,         // Synchronous reset, active high.
  input  wire async_timer_pkg::wb_req_t wb_req_i,      // Wishbone request bundle.
  output logic                          wb_ack_o,      // Wishbone acknowledge.
  output logic [31:0]                   wb_dat_o,      // Wishbone read data.
  input  wire logic                     osc_input_pin, // Slow oscillator pin level.
  input  wire logic                     power_save_i,  // CPU is in power-save sleep.
  input  wire logic                     power_down_i,  // CPU is in power-down sleep.
  output logic                          compare_pin_o, // Compare output pin.
  output logic                          wake_o,        // Wake request to the CPU.
  output logic                          cpu_stall_o,   // Hold the processor after wake.
  output logic                          osc_running_o  // Oscillator enable.
);

  // Oscillator pin synchroniser; stage one feeds stage two only.
  logic       osc_meta_r;
  logic       osc_sync_r;
  logic       osc_prev_r;   // Last synchronised level for edge detection.
  logic       osc_rise;     // One-cycle pulse per oscillator rising edge.
  logic       timer_tick;   // Timer clock event for the selected source.

  // Register state.
  logic       async_sel_r;                                 // Oscillator clock selected.
  logic [7:0] hold_r   [async_timer_pkg::NUM_PATHS];       // Holding registers.
  logic [1:0] edges_r  [async_timer_pkg::NUM_PATHS];       // Edges seen since the write.
  logic [2:0] pend_r;                                      // Pending-update flags.
  logic [7:0] count_r;                                     // Live counter.
  logic [7:0] compare_r;                                   // Active compare value.
  logic [7:0] control_r;                                   // Active control value.
  logic [1:0] flags_r;                                     // Overflow and compare flags.

  // Event path back to the CPU side.
  logic [1:0] evt_raw;                                     // Events in this tick.
  logic [1:0] evt_hold_r;                                  // Events waiting for next tick.
  logic [1:0] evt_pipe_r [async_timer_pkg::FLAG_CPU_DELAY];// CPU-cycle delay line.
  logic [1:0] evt_land;                                    // Events reaching the flags.

  // Bus decode.
  logic       bus_req;
  logic       bus_wr;
  logic [2:0] path_wr;                                     // Write strobe per path.
  logic [1:0] flag_clr;                                    // Write-one-to-clear mask.

  // Wake sequencer.
  async_timer_pkg::wake_state_t wake_state_r;
  logic [2:0] stall_cnt_r;

  // Oscillator pin passes two flops before anything reads it, then one more for edges.
  // [RL20] Two-stage pin synchroniser.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
      osc_prev_r <= 1'b0;
    end else begin
      osc_meta_r <= osc_input_pin;
      osc_sync_r <= osc_meta_r;
      osc_prev_r <= osc_sync_r;
    end
  end

  // Edge seen only after the second stage, never from the first.
  assign osc_rise = osc_sync_r & ~osc_prev_r;

  // [RL19] Timer clock source select.
  assign timer_tick = async_sel_r ? osc_rise : 1'b1;

  // Decode is purely combinational; ack is registered so a request takes two cycles.
  assign bus_req = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_req_i.we & wb_req_i.sel[0];
  assign path_wr[async_timer_pkg::PATH_CONTROL] =
    bus_wr & (wb_req_i.adr == async_timer_pkg::OFS_CONTROL);
  assign path_wr[async_timer_pkg::PATH_COMPARE] =
    bus_wr & (wb_req_i.adr == async_timer_pkg::OFS_COMPARE);
  assign path_wr[async_timer_pkg::PATH_COUNT] =
    bus_wr & (wb_req_i.adr == async_timer_pkg::OFS_COUNT);
  assign flag_clr = (bus_wr && wb_req_i.adr == async_timer_pkg::OFS_FLAGS) ?
                    wb_req_i.dat[1:0] : 2'h0;

  // Acknowledge one cycle after the strobe and drop it the next cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Read mux; unmapped addresses answer with zero.
  // [RL5] Live count, holding copies elsewhere.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (bus_req && !wb_req_i.we) begin
      unique case (wb_req_i.adr)
        async_timer_pkg::OFS_COUNT:   wb_dat_o <= {24'h0, count_r};
        async_timer_pkg::OFS_COMPARE:
          wb_dat_o <= {24'h0, hold_r[async_timer_pkg::PATH_COMPARE]};
        async_timer_pkg::OFS_CONTROL:
          wb_dat_o <= {24'h0, hold_r[async_timer_pkg::PATH_CONTROL]};
        async_timer_pkg::OFS_STATUS:  wb_dat_o <= {28'h0, async_sel_r, pend_r};
        async_timer_pkg::OFS_FLAGS:   wb_dat_o <= {30'h0, flags_r};
        default:                      wb_dat_o <= 32'h0;
      endcase
    end
  end

  // Clock select bit; switching may corrupt in-flight values, which software must handle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      async_sel_r <= 1'b0;
    end else if (bus_wr && wb_req_i.adr == async_timer_pkg::OFS_STATUS) begin
      async_sel_r <= wb_req_i.dat[async_timer_pkg::BIT_ASYNC_SEL];
    end
  end

  // One holding register, edge counter and pending flag per destination.
  // [RL7] Separate transfer paths.
  for (genvar p = 0; p < async_timer_pkg::NUM_PATHS; p++) begin : g_path
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        hold_r[p]  <= async_timer_pkg::RST_BYTE;
        edges_r[p] <= 2'h0;
        pend_r[p]  <= 1'b0;
      end else if (path_wr[p]) begin
        hold_r[p]  <= wb_req_i.dat[7:0];
        edges_r[p] <= 2'h0;
        // [RL1] [RL2] [RL3] Set pending on write while the oscillator clock is selected; clear it otherwise.
        pend_r[p]  <= async_sel_r;
      end else if (pend_r[p] && osc_rise) begin
        // [RL6] Land on the second edge.
        if (edges_r[p] == 2'(async_timer_pkg::XFER_EDGES - 1)) begin
          pend_r[p]  <= 1'b0;
          edges_r[p] <= 2'h0;
        end else begin
          edges_r[p] <= edges_r[p] + 2'h1;
        end
      end
    end
  end

  // Transfer strobes: immediate in synchronous mode, second edge otherwise.
  logic [2:0] xfer;
  for (genvar q = 0; q < async_timer_pkg::NUM_PATHS; q++) begin : g_xfer
    assign xfer[q] = (path_wr[q] & ~async_sel_r) |
      (pend_r[q] & osc_rise & ~path_wr[q] &
       (edges_r[q] == 2'(async_timer_pkg::XFER_EDGES - 1)));
  end

  // Active control and compare registers take their holding copies on transfer, or the bus data directly in synchronous mode.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_r <= async_timer_pkg::RST_BYTE;
      compare_r <= async_timer_pkg::RST_BYTE;
    end else begin
      if (xfer[async_timer_pkg::PATH_CONTROL]) begin
        control_r <= async_sel_r ? hold_r[async_timer_pkg::PATH_CONTROL] : wb_req_i.dat[7:0];
      end
      if (xfer[async_timer_pkg::PATH_COMPARE]) begin
        compare_r <= async_sel_r ? hold_r[async_timer_pkg::PATH_COMPARE] : wb_req_i.dat[7:0];
      end
    end
  end

  // Counter: a transfer replaces the tick; otherwise count on each tick when enabled.
  logic count_en;
  assign count_en = timer_tick & (control_r[async_timer_pkg::CTL_CS_MSB:0] != 3'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= async_timer_pkg::RST_BYTE;
    end else if (xfer[async_timer_pkg::PATH_COUNT]) begin
      count_r <= async_sel_r ? hold_r[async_timer_pkg::PATH_COUNT] : wb_req_i.dat[7:0];
    end else if (count_en) begin
      count_r <= count_r + 8'h01;
    end
  end

  // Events of this tick; a compare match is blocked while a count or compare write waits.
  // [RL9] Suppress match during pending writes.
  assign evt_raw[async_timer_pkg::BIT_FLAG_OVF] = count_en & (count_r == 8'hff) &
    ~xfer[async_timer_pkg::PATH_COUNT];
  assign evt_raw[async_timer_pkg::BIT_FLAG_CMP] = count_en &
    ((count_r + 8'h01) == compare_r) & ~xfer[async_timer_pkg::PATH_COUNT] &
    ~pend_r[async_timer_pkg::PATH_COUNT] & ~pend_r[async_timer_pkg::PATH_COMPARE];

  // Compare pin changes on the timer tick itself, with no extra CPU-side stage.
  // [RL18] Pin follows the timer tick.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_pin_o <= 1'b0;
    end else if (evt_raw[async_timer_pkg::BIT_FLAG_CMP] &&
                 control_r[async_timer_pkg::BIT_CTL_TOGGLE]) begin
      compare_pin_o <= ~compare_pin_o;
    end
  end

  // Events wait one timer tick, then walk a three-stage CPU delay line.
  // [RL17] One tick plus three cycles.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_hold_r <= 2'h0;
      for (int i = 0; i < async_timer_pkg::FLAG_CPU_DELAY; i++) begin
        evt_pipe_r[i] <= 2'h0;
      end
    end else begin
      evt_hold_r    <= timer_tick ? evt_raw : (evt_hold_r | evt_raw);
      evt_pipe_r[0] <= timer_tick ? evt_hold_r : 2'h0;
      for (int i = 1; i < async_timer_pkg::FLAG_CPU_DELAY; i++) begin
        evt_pipe_r[i] <= evt_pipe_r[i-1];
      end
    end
  end

  assign evt_land = evt_pipe_r[async_timer_pkg::FLAG_CPU_DELAY-1];

  // Sticky flags; an arriving event beats a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_r <= 2'h0;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | evt_land;
    end
  end

  // Wake sequencer: event in power-save, wait a tick, stall, then rearm for one tick.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_state_r <= async_timer_pkg::WK_IDLE;
      stall_cnt_r  <= 3'h0;
      wake_o       <= 1'b0;
      cpu_stall_o  <= 1'b0;
    end else begin
      unique case (wake_state_r)
        async_timer_pkg::WK_IDLE: begin
          // Only an armed sequencer can raise a wake.
          if (power_save_i && evt_raw != 2'h0) begin
            wake_state_r <= async_timer_pkg::WK_WAIT;
          end
        end
        async_timer_pkg::WK_WAIT: begin
          // [RL15] Wake on the following tick.
          if (timer_tick) begin
            wake_state_r <= async_timer_pkg::WK_STALL;
            wake_o       <= 1'b1;
            cpu_stall_o  <= 1'b1;
            stall_cnt_r  <= 3'h0;
          end
        end
        async_timer_pkg::WK_STALL: begin
          wake_o <= 1'b0;
          // [RL16] Hold the processor four cycles.
          if (stall_cnt_r == 3'(async_timer_pkg::WAKE_STALL - 1)) begin
            cpu_stall_o  <= 1'b0;
            wake_state_r <= async_timer_pkg::WK_REARM;
          end else begin
            stall_cnt_r <= stall_cnt_r + 3'h1;
          end
        end
        async_timer_pkg::WK_REARM: begin
          // [RL11] Rearm after one oscillator cycle.
          if (timer_tick) begin
            wake_state_r <= async_timer_pkg::WK_IDLE;
          end
        end
      endcase
    end
  end

  // Oscillator runs while selected, in every sleep state but power-down.
  // [RL13] Oscillator enable.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_running_o <= 1'b0;
    end else begin
      osc_running_o <= async_sel_r & ~power_down_i;
    end
  end

endmodule

`default_nettype wire

// File: testbench/async_timer_register_sync_chk.sv
// Purpose: Port-level checker for the timer register crossing.
// Assumes: Single clock clk_i, synchronous active-high reset rst_i.
// Notes:   Sees only the top ports, so internal timing is judged by its effects.
`default_nettype none

module async_timer_register_sync_chk (
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  input wire async_timer_pkg::wb_req_t wb_req_i,
  input wire logic                     wb_ack_o,
  input wire logic [31:0]              wb_dat_o,
  input wire logic                     osc_input_pin,
  input wire logic                     power_save_i,
  input wire logic                     power_down_i,
  input wire logic                     compare_pin_o,
  input wire logic                     wake_o,
  input wire logic                     cpu_stall_o,
  input wire logic                     osc_running_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // All checks share the one clock; all but a_reset_quiet are disabled by its reset.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A taken request is answered on the very next edge.
  a_ack_follows_req: assert property (
    wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_req_i.cyc && wb_req_i.stb))
    else $error("ack without request");
  // Read data may only move after a read was taken.
  a_read_data_stands: assert property ($changed(wb_dat_o)
    |-> $past(wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we && !wb_ack_o))
    else $error("read data moved without a read");
  a_upper_bytes_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // The processor hold lasts exactly four cycles and starts with the wake.
  a_stall_four_cycles: assert property (
    $rose(cpu_stall_o) |-> cpu_stall_o [*4] ##1 !cpu_stall_o)
    else $error("stall length wrong");
  a_wake_starts_stall: assert property (wake_o |-> $rose(cpu_stall_o))
    else $error("wake without stall start");
  // No second wake while the processor is still held in its stall.
  a_wake_lockout: assert property (cpu_stall_o |=> !wake_o)
    else $error("wake during stall");
  a_osc_stops_down: assert property (power_down_i |=> !osc_running_o)
    else $error("oscillator runs in power-down");
  // Reset must quiet every output but the read data, so this one is never disabled.
  a_reset_quiet: assert property (disable iff (1'b0)
    rst_i |=> !wb_ack_o && !wake_o && !cpu_stall_o && !compare_pin_o && !osc_running_o)
    else $error("outputs active after reset");

  // Main scenarios reached.
  c_write_acked: cover property (wb_ack_o && wb_req_i.we);
  c_wake_seen: cover property (wake_o);
  c_pin_toggled: cover property ($changed(compare_pin_o));
endmodule

bind async_timer_register_sync async_timer_register_sync_chk async_timer_register_sync_chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .osc_input_pin(osc_input_pin), .power_save_i(power_save_i),
  .power_down_i(power_down_i), .compare_pin_o(compare_pin_o), .wake_o(wake_o),
  .cpu_stall_o(cpu_stall_o), .osc_running_o(osc_running_o));

`default_nettype wire

// File: testbench/async_timer_register_sync_test.sv
// Purpose: Self-checking bench for the timer register crossing.
// Assumes: Bench alone drives the Wishbone port and the oscillator pin.
// Notes:   The oscillator is pulsed by hand so every transfer edge is known.
`default_nettype none

module async_timer_register_sync_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic                     clk_i = 1'b0;  // 125 MHz system clock.
  logic                     rst_i = 1'b1;  // Held high at start.
  logic                     osc   = 1'b0;  // Oscillator pin, idle low between pulses.
  logic                     ps    = 1'b0;  // Power-save request.
  logic                     pd    = 1'b0;  // Power-down request.
  async_timer_pkg::wb_req_t req   = '0;    // Bus request bundle.
  logic                     ack, pin, wake, stall, run;
  logic [31:0]              dat;
  logic [7:0]               q, r;          // Last read byte and a saved count.
  int                       bad_count = 0, n_checks = 0, cycles = 0, wake_n = 0, stall_n = 0;

  always #4 clk_i = ~clk_i;

  async_timer_register_sync async_timer_register_sync_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_ack_o(ack), .wb_dat_o(dat),
    .osc_input_pin(osc), .power_save_i(ps), .power_down_i(pd), .compare_pin_o(pin),
    .wake_o(wake), .cpu_stall_o(stall), .osc_running_o(run));

  // Count wakes and stall cycles; a hang is cut off well past the expected run.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (wake) wake_n <= wake_n + 1;
    if (stall) stall_n <= stall_n + 1;
    if (cycles > 20000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic cycle; ack is sampled at the edge, then the request drops a cycle.
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] d);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: adr, dat: {24'h0, d}};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat[7:0];
    req <= '0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    bus(1'b1, adr, d);
  endtask

  task automatic rd(input string name, input logic [7:0] adr, input logic [7:0] exp);
    bus(1'b0, adr, 8'h00);
    check(name, q, exp);
  endtask

  // Each pulse is long enough for the two-flop synchroniser and edge detector to see it.
  task automatic pulse(input int n);
    repeat (n) begin
      osc <= 1'b1;
      repeat (6) @(posedge clk_i);
      osc <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("count", async_timer_pkg::OFS_COUNT, 8'h00);
    rd("status", async_timer_pkg::OFS_STATUS, 8'h00);
    rd("flags", async_timer_pkg::OFS_FLAGS, 8'h00);
    rd("unmapped", 8'h14, 8'h00);
    $display("test reset done");
    // Synchronous mode: writes land at once and raise no pending flag.
    wr(async_timer_pkg::OFS_COMPARE, 8'h55);
    rd("compare", async_timer_pkg::OFS_COMPARE, 8'h55);
    wr(async_timer_pkg::OFS_COUNT, 8'h10);
    rd("count", async_timer_pkg::OFS_COUNT, 8'h10);
    rd("status", async_timer_pkg::OFS_STATUS, 8'h00);
    $display("test sync done");
    // Clock switch: select, rewrite all three, wait, clear flags.
    wr(async_timer_pkg::OFS_STATUS, 8'h08);
    rd("status", async_timer_pkg::OFS_STATUS, 8'h08);
    check("running", {7'h0, run}, 8'h01);
    pd <= 1'b1;
    repeat (2) @(posedge clk_i);
    check("running", {7'h0, run}, 8'h00);
    pd <= 1'b0;
    // Contents count as lost after power-down, so all three are rewritten.
    // Overlapping transfers on three independent paths.
    wr(async_timer_pkg::OFS_COMPARE, 8'h22);
    rd("status", async_timer_pkg::OFS_STATUS, 8'h0a);
    pulse(1);
    wr(async_timer_pkg::OFS_COUNT, 8'h20);
    rd("status", async_timer_pkg::OFS_STATUS, 8'h0e);
    wr(async_timer_pkg::OFS_CONTROL, 8'h00);
    rd("status", async_timer_pkg::OFS_STATUS, 8'h0f);
    rd("compare", async_timer_pkg::OFS_COMPARE, 8'h22);
    pulse(1);
    rd("status", async_timer_pkg::OFS_STATUS, 8'h0d);
    pulse(1);
    rd("status", async_timer_pkg::OFS_STATUS, 8'h08);
    rd("count", async_timer_pkg::OFS_COUNT, 8'h20);
    // Flags cleared once every path has landed.
    wr(async_timer_pkg::OFS_FLAGS, 8'h03);
    $display("test transfer done");
    // Counting with toggle; a match during a count write is suppressed.
    // Nothing is pending, so this write is safe.
    wr(async_timer_pkg::OFS_CONTROL, 8'h11);
    pulse(2);
    bus(1'b0, async_timer_pkg::OFS_COUNT, 8'h00);
    r = q;
    wr(async_timer_pkg::OFS_COMPARE, r + 8'h04);
    pulse(3);
    wr(async_timer_pkg::OFS_COUNT, 8'h00);
    pulse(2);
    rd("flags", async_timer_pkg::OFS_FLAGS, 8'h00);
    check("pin", {7'h0, pin}, 8'h00);
    wr(async_timer_pkg::OFS_COUNT, r + 8'h02);
    pulse(2);
    // Sleep only once the written value has landed.
    rd("status", async_timer_pkg::OFS_STATUS, 8'h08);
    ps <= 1'b1;
    pulse(2);
    rd("flags", async_timer_pkg::OFS_FLAGS, 8'h00);
    pulse(1);
    rd("flags", async_timer_pkg::OFS_FLAGS, 8'h02);
    check("pin", {7'h0, pin}, 8'h01);
    check("wakes", 8'(wake_n), 8'h01);
    check("stall", 8'(stall_n), 8'h04);
    rd("count", async_timer_pkg::OFS_COUNT, r + 8'h05);
    ps <= 1'b0;
    wr(async_timer_pkg::OFS_FLAGS, 8'h02);
    rd("flags", async_timer_pkg::OFS_FLAGS, 8'h00);
    $display("test match done");
    // Write, wait for pending to clear, then sleep again for an overflow wake.
    wr(async_timer_pkg::OFS_COUNT, 8'hfe);
    pulse(2);
    rd("status", async_timer_pkg::OFS_STATUS, 8'h08);
    ps <= 1'b1;
    pulse(3);
    rd("flags", async_timer_pkg::OFS_FLAGS, 8'h01);
    check("wakes", 8'(wake_n), 8'h02);
    check("stall", 8'(stall_n), 8'h08);
    rd("count", async_timer_pkg::OFS_COUNT, 8'h01);
    ps <= 1'b0;
    $display("test rearm done");
    complete_run();
  end
endmodule

`default_nettype wire
